// file: pkg/lsc_defs.svh
// Constants of the load/store unit control block
// ----------------------------------------------------------------------
// Functional notes
// - Entry read is two steps: port read fills holding register, second read returns it.
// - Every read or write of the entry port advances the entry pointer.
// - Data fault or miss captures virtual address and fault details.
// - Capture locks address and status until address is read or unlock is written; reset unlocked.
// - Status bits change only on an error or a miss while unlocked or in the unlocking cycle.
// - Status shows opcode in 14:9, destination field in 8:4, zero above.
// - Status bit 3 store fault, 2 load fault, 1 violation, 0 write.
// - Invalidate-all write clears all 36 entries and resets the replacement pointer.
// - Non-global invalidate write clears entries whose address-space-match bit is zero.
// - Single invalidate clears the entry mapping the address in the write data.
// - Cache flush write flushes whole cache; non-global flush only unmatched blocks.
// - Control bits 15:12 exist only on the later variant.
// - Bit 15 makes external invalidates clear both blocks at index 12:5.
// - Bit 14 parity check off, 13 bad tag parity, 12 larger cache.
// - Bit 10 enables cache, clearing flushes it; bit 11 forces hits.
// - Bit 8 keeps uncached references from disturbing cache; bit 9 kept clear.
// - Bit 6 inverts physical address bit 2 on data references.
// - Bit 5 maps addresses with 42:41 equal 2 one-to-one, kernel only.
// - Bit 4 maps addresses with 42:30 equal 1ffe to low space, kernel only.
// - Bit 2 on earlier variant raises interrupt on soft-error acknowledge.
// - Bit 1 sends uncorrectable errors to machine check, else lock error status.
// - Bit 3 enables stream buffer; bit 0 stops write buffer unloading.
// ----------------------------------------------------------------------
`ifndef LSC_DEFS_SVH
`define LSC_DEFS_SVH

// Register selects on the move port
`define LSC_SEL_ENTRY_PORT   4'h0
`define LSC_SEL_READBACK     4'h1
`define LSC_SEL_FAULT_STATUS 4'h2
`define LSC_SEL_FAULT_ADDR   4'h3
`define LSC_SEL_INV_ALL      4'h4
`define LSC_SEL_INV_NONGLOB  4'h5
`define LSC_SEL_INV_SINGLE   4'h6
`define LSC_SEL_IC_FLUSH     4'h7
`define LSC_SEL_IC_FLUSH_NG  4'h8
`define LSC_SEL_CONTROL      4'h9
`define LSC_SEL_FAULT_UNLOCK 4'ha

// Fault status fields
`define LSC_FS_OPC_HI  14
`define LSC_FS_OPC_LO  9
`define LSC_FS_DST_HI  8
`define LSC_FS_DST_LO  4
`define LSC_FS_FOW     3
`define LSC_FS_FOR     2
`define LSC_FS_ACV     1
`define LSC_FS_WR      0

// Control bits
`define LSC_CB_DUAL_INV  15
`define LSC_CB_NOPAR     14
`define LSC_CB_BADTAG    13
`define LSC_CB_DC16K     12
`define LSC_CB_FHIT      11
`define LSC_CB_DATA_CACHE_ENABLE     10
`define LSC_CB_NODISTURB 8
`define LSC_CB_STC       7
`define LSC_CB_ENDIAN    6
`define LSC_CB_SPE2      5
`define LSC_CB_SPE1      4
`define LSC_CB_SBUF      3
`define LSC_CB_CRD       2
`define LSC_CB_MCHK      1
`define LSC_CB_WBDIS     0
`define LSC_CTL_RESET    16'h0000
`define LSC_CTL_LATE_MSK 16'hf000

// Entry layout and counts
`define LSC_PTE_ASM_BIT  34
`define LSC_SMALL_ENTRIES 32
`define LSC_LARGE_ENTRIES 4
`define LSC_SPE2_TAG     2'h2
`define LSC_SPE1_TAG     13'h1ffe
`define LSC_ACK_SOFT_ERR 3'h5

`endif

// file: pkg/lsc_pkg.sv
// Types of the load/store unit control block
package lsc_pkg;
  typedef enum logic [1:0] {
    LSC_IDLE = 2'b01,
    LSC_RDWT = 2'b10
  } lsc_rd_state_t;
endpackage

// file: pkg/lsc_ent_if.sv
// Carrier between control logic and translation entry store
`timescale 1ns/1ps
`default_nettype none
interface lsc_ent_if #(parameter int N = 36, parameter int IW = 6);
  logic          wr;
  logic          rd;
  logic [IW-1:0] idx;
  logic [63:0]   wdata;
  logic [29:0]   wtag;
  logic          inv_all;
  logic          inv_ng;
  logic          inv_one;
  logic [29:0]   inv_tag;
  logic [63:0]   rdata;
  modport ctl (output wr, rd, idx, wdata, wtag, inv_all, inv_ng, inv_one, inv_tag,
               input rdata);
  modport mem (input wr, rd, idx, wdata, wtag, inv_all, inv_ng, inv_one, inv_tag,
               output rdata);
endinterface
`default_nettype wire

// file: design/lsc_entry_store.sv
// Translation entry store with valid, match bits and registered readback
`include "lsc_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module lsc_entry_store #(
  parameter int N = 36
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  lsc_ent_if.mem   ent
);
  logic [63:0] pte_r [N];
  logic [29:0] tag_r [N];
  logic [N-1:0] vld_r;
  logic [N-1:0] vld_nxt;
  logic [63:0] rdata_r;
  logic [63:0] rdata_nxt;

  // ----------------------------------------
  // Per-entry invalidation
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_ent
      always_comb begin
        vld_nxt[g] = vld_r[g];
        if (ent.wr && ent.idx == 6'(g)) begin
          vld_nxt[g] = 1'b1;
        end
        if (ent.inv_all) begin
          vld_nxt[g] = 1'b0;
        end else if (ent.inv_ng && !pte_r[g][`LSC_PTE_ASM_BIT]) begin
          vld_nxt[g] = 1'b0;
        end else if (ent.inv_one && tag_r[g] == ent.inv_tag) begin
          vld_nxt[g] = 1'b0;
        end
      end
      always_ff @(posedge clk_in) begin
        if (ent.wr && ent.idx == 6'(g)) begin
          pte_r[g] <= ent.wdata;
          tag_r[g] <= ent.wtag;
        end
      end
    end
  endgenerate

  always_comb begin
    rdata_nxt = rdata_r;
    if (ent.rd) begin
      rdata_nxt = pte_r[ent.idx];
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      vld_r   <= '0;
      rdata_r <= 64'h0;
    end else begin
      vld_r   <= vld_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign ent.rdata = rdata_r;
endmodule
`default_nettype wire

// file: design/lsc_top.sv
// Load/store unit control: fault capture, entry access, invalidates, control
`include "lsc_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module lsc_top #(
  parameter bit LATE_VARIANT = 1'b1,
  parameter int N_ENTRIES    = `LSC_SMALL_ENTRIES + `LSC_LARGE_ENTRIES
) (
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        resetn_in,
  // Privileged register move port
  input  wire logic        mv_valid_in,
  input  wire logic        mv_write_in,
  input  wire logic [3:0]  mv_sel_in,
  input  wire logic [63:0] mv_wdata_in,
  input  wire logic [29:0] mv_tag_in,
  output logic             mv_rvalid_out,
  output logic [63:0]      mv_rdata_out,
  // Fault reports from the address path
  input  wire logic        fault_valid_in,
  input  wire logic [63:0] fault_va_in,
  input  wire logic [5:0]  fault_opcode_in,
  input  wire logic [4:0]  fault_dest_in,
  input  wire logic        fault_store_in,
  input  wire logic        fault_load_in,
  input  wire logic        fault_acv_in,
  input  wire logic        fault_write_in,
  output logic             fault_locked_out,
  // Data-stream address mapping
  input  wire logic        ds_valid_in,
  input  wire logic [42:0] ds_va_in,
  input  wire logic [33:0] ds_pa_in,
  input  wire logic        kernel_mode_in,
  output logic [33:0]      ds_pa_out,
  output logic             ds_superpage_out,
  // External invalidate and bus events
  input  wire logic        external_invalidate_request_in,
  input  wire logic [12:5] invalidate_address_bus_in,
  input  wire logic        cycle_ack_valid_in,
  input  wire logic [2:0]  cycle_acknowledge_code_in,
  input  wire logic        uncorrectable_error_in,
  output logic             dc_inval_valid_out,
  output logic [12:5]      dc_inval_index_out,
  output logic             dc_inval_both_out,
  output logic             corrected_read_irq_out,
  output logic             machine_check_out,
  output logic             error_status_lock_out,
  // Cache flush strobes
  output logic             dc_flush_out,
  output logic             ic_flush_out,
  output logic             ic_flush_nonglobal_out,
  // Control levels
  output logic [15:0]      control_out
);
  localparam int IW = 6;

  lsc_ent_if #(.N(N_ENTRIES), .IW(IW)) ent ();

  lsc_entry_store #(.N(N_ENTRIES)) u_store (
    .clk_in    (clk_in),
    .resetn_in (resetn_in),
    .ent       (ent)
  );

  // ----------------------------------------
  // Decode of the move port
  // ----------------------------------------
  logic wr_any;
  logic rd_any;
  logic wr_ent;
  logic rd_ent;
  logic wr_ctl;
  logic rd_va;
  logic wr_unlock;
  logic wr_inv_all;
  logic wr_inv_ng;
  logic wr_inv_one;
  logic wr_ic;
  logic wr_ic_ng;

  always_comb begin
    wr_any     = mv_valid_in && mv_write_in;
    rd_any     = mv_valid_in && !mv_write_in;
    wr_ent     = wr_any && mv_sel_in == `LSC_SEL_ENTRY_PORT;
    rd_ent     = rd_any && mv_sel_in == `LSC_SEL_ENTRY_PORT;
    wr_ctl     = wr_any && mv_sel_in == `LSC_SEL_CONTROL;
    rd_va      = rd_any && mv_sel_in == `LSC_SEL_FAULT_ADDR;
    wr_unlock  = wr_any && mv_sel_in == `LSC_SEL_FAULT_UNLOCK;
    wr_inv_all = wr_any && mv_sel_in == `LSC_SEL_INV_ALL;
    wr_inv_ng  = wr_any && mv_sel_in == `LSC_SEL_INV_NONGLOB;
    wr_inv_one = wr_any && mv_sel_in == `LSC_SEL_INV_SINGLE;
    wr_ic      = wr_any && mv_sel_in == `LSC_SEL_IC_FLUSH;
    wr_ic_ng   = wr_any && mv_sel_in == `LSC_SEL_IC_FLUSH_NG;
  end

  // ----------------------------------------
  // Entry pointer
  // ----------------------------------------
  logic [IW-1:0] ptr_r;
  logic [IW-1:0] ptr_nxt;
  localparam logic [IW-1:0] PTR_LAST = IW'(N_ENTRIES - 1);

  always_comb begin
    ptr_nxt = ptr_r;
    if (wr_ent || rd_ent) begin
      ptr_nxt = (ptr_r == PTR_LAST) ? '0 : ptr_r + 1'b1;
    end
    // A zap in the same cycle as an access still leaves the pointer at start
    if (wr_inv_all) begin
      ptr_nxt = '0;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ptr_r <= '0;
    end else begin
      ptr_r <= ptr_nxt;
    end
  end

  // Invalidate writes store no data; single invalidate takes its tag from write data 42:13
  always_comb begin
    ent.wr      = wr_ent;
    ent.rd      = rd_ent;
    ent.idx     = ptr_r;
    ent.wdata   = mv_wdata_in;
    ent.wtag    = mv_tag_in;
    ent.inv_all = wr_inv_all;
    ent.inv_ng  = wr_inv_ng;
    ent.inv_one = wr_inv_one;
    ent.inv_tag = mv_wdata_in[42:13];
  end

  // ----------------------------------------
  // Fault address and status capture
  // ----------------------------------------
  logic [63:0] fva_r;
  logic [63:0] fva_nxt;
  logic [14:0] fst_r;
  logic [14:0] fst_nxt;
  logic        lock_r;
  logic        lock_nxt;
  logic        unlock_req;
  logic        take;

  always_comb begin
    fva_nxt    = fva_r;
    fst_nxt    = fst_r;
    lock_nxt   = lock_r;
    unlock_req = rd_va || wr_unlock;
    // A fault in the unlocking cycle is captured, so set wins over clear
    take       = fault_valid_in && (!lock_r || unlock_req);
    if (take) begin
      fva_nxt  = fault_va_in;
      fst_nxt[`LSC_FS_OPC_HI:`LSC_FS_OPC_LO] = fault_opcode_in;
      fst_nxt[`LSC_FS_DST_HI:`LSC_FS_DST_LO] = fault_dest_in;
      fst_nxt[`LSC_FS_FOW] = fault_store_in && fault_write_in;
      fst_nxt[`LSC_FS_FOR] = fault_load_in && !fault_write_in;
      fst_nxt[`LSC_FS_ACV] = fault_acv_in;
      fst_nxt[`LSC_FS_WR]  = fault_write_in;
      lock_nxt = 1'b1;
    end else if (unlock_req) begin
      lock_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      fva_r  <= 64'h0;
      fst_r  <= 15'h0;
      lock_r <= 1'b0;
    end else begin
      fva_r  <= fva_nxt;
      fst_r  <= fst_nxt;
      lock_r <= lock_nxt;
    end
  end

  // ----------------------------------------
  // Control register
  // ----------------------------------------
  logic [15:0] ctl_r;
  logic [15:0] ctl_nxt;
  localparam logic [15:0] CTL_MASK = LATE_VARIANT ? 16'hffff : ~`LSC_CTL_LATE_MSK;

  always_comb begin
    ctl_nxt = ctl_r;
    if (wr_ctl) begin
      // Earlier variant keeps the upper nibble at zero
      ctl_nxt = mv_wdata_in[15:0] & CTL_MASK;
      // Bit 9 is not defined and stays zero
      ctl_nxt[9] = 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ctl_r <= `LSC_CTL_RESET;
    end else begin
      ctl_r <= ctl_nxt;
    end
  end

  // ----------------------------------------
  // Read answers
  // ----------------------------------------
  logic          rv_r;
  logic          rv_nxt;
  logic [63:0]   rd_r;
  logic [63:0]   rd_nxt;
  lsc_pkg::lsc_rd_state_t rs_r;
  lsc_pkg::lsc_rd_state_t rs_nxt;

  // Readback of the holding register answers at once after a port read,
  // which loads it on its own edge, so back-to-back reads return fresh data.
  always_comb begin
    rs_nxt = rs_r;
    rv_nxt = 1'b0;
    rd_nxt = rd_r;
    unique case (rs_r)
      lsc_pkg::LSC_IDLE: begin
        if (rd_any) begin
          rv_nxt = 1'b1;
          unique case (mv_sel_in)
            `LSC_SEL_READBACK: begin
              rd_nxt = ent.rdata;
            end
            `LSC_SEL_FAULT_STATUS: begin
              rd_nxt = {49'h0, fst_r};
            end
            `LSC_SEL_FAULT_ADDR: begin
              rd_nxt = fva_r;
            end
            default: begin
              rd_nxt = 64'h0;
            end
          endcase
          if (rd_ent) begin
            rs_nxt = lsc_pkg::LSC_RDWT;
          end
        end
      end
      lsc_pkg::LSC_RDWT: begin
        rs_nxt = lsc_pkg::LSC_IDLE;
        if (rd_any && mv_sel_in == `LSC_SEL_READBACK) begin
          rv_nxt = 1'b1;
          rd_nxt = ent.rdata;
        end else if (rd_any) begin
          rv_nxt = 1'b1;
          rd_nxt = (mv_sel_in == `LSC_SEL_FAULT_STATUS) ? {49'h0, fst_r} :
                   (mv_sel_in == `LSC_SEL_FAULT_ADDR) ? fva_r : 64'h0;
          if (rd_ent) begin
            rs_nxt = lsc_pkg::LSC_RDWT;
          end
        end
      end
      default: begin
        rs_nxt = lsc_pkg::LSC_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rs_r <= lsc_pkg::LSC_IDLE;
      rv_r <= 1'b0;
      rd_r <= 64'h0;
    end else begin
      rs_r <= rs_nxt;
      rv_r <= rv_nxt;
      rd_r <= rd_nxt;
    end
  end

  // ----------------------------------------
  // Data-stream mapping and events
  // ----------------------------------------
  logic [33:0] pa_r;
  logic [33:0] pa_nxt;
  logic        sp_r;
  logic        sp_nxt;
  logic        dv_r;
  logic        dv_nxt;
  logic [12:5] di_r;
  logic [12:5] di_nxt;
  logic        db_r;
  logic        db_nxt;
  logic        crd_r;
  logic        crd_nxt;
  logic        mc_r;
  logic        mc_nxt;
  logic        el_r;
  logic        el_nxt;
  logic        dcf_r;
  logic        dcf_nxt;
  logic        icf_r;
  logic        icf_nxt;
  logic        icn_r;
  logic        icn_nxt;

  always_comb begin
    pa_nxt = ds_pa_in;
    sp_nxt = 1'b0;
    if (ds_valid_in && kernel_mode_in) begin
      if (ctl_r[`LSC_CB_SPE2] && ds_va_in[42:41] == `LSC_SPE2_TAG) begin
        pa_nxt = {ds_va_in[33:13], ds_va_in[12:0]};
        sp_nxt = 1'b1;
      end else if (ctl_r[`LSC_CB_SPE1] && ds_va_in[42:30] == `LSC_SPE1_TAG) begin
        pa_nxt = {4'h0, ds_va_in[29:0]};
        sp_nxt = 1'b1;
      end
    end
    if (ctl_r[`LSC_CB_ENDIAN]) begin
      pa_nxt[2] = ~pa_nxt[2];
    end
    dv_nxt  = external_invalidate_request_in;
    di_nxt  = invalidate_address_bus_in;
    db_nxt  = external_invalidate_request_in && ctl_r[`LSC_CB_DUAL_INV];
    crd_nxt = !LATE_VARIANT && ctl_r[`LSC_CB_CRD] && cycle_ack_valid_in &&
              cycle_acknowledge_code_in == `LSC_ACK_SOFT_ERR;
    mc_nxt  = uncorrectable_error_in && ctl_r[`LSC_CB_MCHK];
    el_nxt  = uncorrectable_error_in && !ctl_r[`LSC_CB_MCHK];
    dcf_nxt = wr_ctl && !mv_wdata_in[`LSC_CB_DATA_CACHE_ENABLE];
    icf_nxt = wr_ic;
    icn_nxt = wr_ic_ng;
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pa_r  <= 34'h0;
      sp_r  <= 1'b0;
      dv_r  <= 1'b0;
      di_r  <= 8'h0;
      db_r  <= 1'b0;
      crd_r <= 1'b0;
      mc_r  <= 1'b0;
      el_r  <= 1'b0;
      dcf_r <= 1'b0;
      icf_r <= 1'b0;
      icn_r <= 1'b0;
    end else begin
      pa_r  <= pa_nxt;
      sp_r  <= sp_nxt;
      dv_r  <= dv_nxt;
      di_r  <= di_nxt;
      db_r  <= db_nxt;
      crd_r <= crd_nxt;
      mc_r  <= mc_nxt;
      el_r  <= el_nxt;
      dcf_r <= dcf_nxt;
      icf_r <= icf_nxt;
      icn_r <= icn_nxt;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Control levels go out as stored: 15..12 11/10 8/7
  // 3/0 the consumer units act on them.
  assign control_out            = ctl_r;
  assign mv_rvalid_out          = rv_r;
  assign mv_rdata_out           = rd_r;
  assign fault_locked_out       = lock_r;
  assign ds_pa_out              = pa_r;
  assign ds_superpage_out       = sp_r;
  assign dc_inval_valid_out     = dv_r;
  assign dc_inval_index_out     = di_r;
  assign dc_inval_both_out      = db_r;
  assign corrected_read_irq_out = crd_r;
  assign machine_check_out      = mc_r;
  assign error_status_lock_out  = el_r;
  assign dc_flush_out           = dcf_r;
  assign ic_flush_out           = icf_r;
  assign ic_flush_nonglobal_out = icn_r;
endmodule
`default_nettype wire

// file: bench/lsc_top_props.sv
// Checker on the ports of the load/store unit control top
`timescale 1ns/1ps
`default_nettype none
module lsc_top_props (
  // Clock and reset
  input wire logic        clk_in,
  input wire logic        resetn_in,
  // Move port
  input wire logic        mv_valid_in,
  input wire logic        mv_write_in,
  input wire logic [3:0]  mv_sel_in,
  input wire logic [63:0] mv_wdata_in,
  input wire logic        mv_rvalid_out,
  input wire logic [63:0] mv_rdata_out,
  // Events and answers
  input wire logic        fault_valid_in,
  input wire logic        fault_locked_out,
  input wire logic        external_invalidate_request_in,
  input wire logic [12:5] invalidate_address_bus_in,
  input wire logic        uncorrectable_error_in,
  input wire logic        dc_inval_valid_out,
  input wire logic [12:5] dc_inval_index_out,
  input wire logic        dc_inval_both_out,
  input wire logic        machine_check_out,
  input wire logic        error_status_lock_out,
  input wire logic        dc_flush_out,
  input wire logic        ic_flush_out,
  input wire logic [15:0] control_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  logic rd_c;
  logic wr_c;
  logic rel_c;
  assign rd_c = mv_valid_in && !mv_write_in;
  assign wr_c = mv_valid_in && mv_write_in;
  // Two ways out of the lock: address read or explicit unlock write
  assign rel_c = (rd_c && mv_sel_in == 4'h3) || (wr_c && mv_sel_in == 4'ha);

  a_read_answer: assert property (rd_c |=> mv_rvalid_out)
    else $error("read got no answer");
  a_write_silent: assert property (wr_c |=> !mv_rvalid_out)
    else $error("write produced a read answer");
  a_fault_lock: assert property (fault_valid_in && (!fault_locked_out || rel_c)
    |=> fault_locked_out) else $error("fault did not lock");
  a_lock_release: assert property (fault_locked_out && rel_c && !fault_valid_in
    |=> !fault_locked_out) else $error("lock not released");
  a_lock_hold: assert property (fault_locked_out && !rel_c |=> fault_locked_out)
    else $error("lock dropped without release");
  a_status_zero: assert property (rd_c && mv_sel_in == 4'h2
    |=> mv_rdata_out[63:15] == '0) else $error("status upper bits not zero");
  a_ic_flush: assert property (wr_c && mv_sel_in == 4'h7 |=> ic_flush_out)
    else $error("icache flush missing");
  a_dc_flush: assert property (wr_c && mv_sel_in == 4'h9 && !mv_wdata_in[10]
    |=> dc_flush_out) else $error("dcache flush missing");
  a_dual_inval: assert property (external_invalidate_request_in
    |=> dc_inval_valid_out && dc_inval_index_out == $past(invalidate_address_bus_in)
    && dc_inval_both_out == $past(control_out[15])) else $error("bad invalidate copy");
  a_error_route: assert property (uncorrectable_error_in
    |=> machine_check_out == $past(control_out[1])
    && error_status_lock_out != $past(control_out[1])) else $error("bad error route");

  c_release: cover property (fault_locked_out && rel_c);
  c_dual: cover property (external_invalidate_request_in && control_out[15]);
  c_mchk: cover property (uncorrectable_error_in && control_out[1]);
endmodule

bind lsc_top lsc_top_props u_props (
  .clk_in(clk_in), .resetn_in(resetn_in), .mv_valid_in(mv_valid_in),
  .mv_write_in(mv_write_in), .mv_sel_in(mv_sel_in), .mv_wdata_in(mv_wdata_in),
  .mv_rvalid_out(mv_rvalid_out), .mv_rdata_out(mv_rdata_out),
  .fault_valid_in(fault_valid_in), .fault_locked_out(fault_locked_out),
  .external_invalidate_request_in(external_invalidate_request_in),
  .invalidate_address_bus_in(invalidate_address_bus_in),
  .uncorrectable_error_in(uncorrectable_error_in), .dc_inval_valid_out(dc_inval_valid_out),
  .dc_inval_index_out(dc_inval_index_out), .dc_inval_both_out(dc_inval_both_out),
  .machine_check_out(machine_check_out), .error_status_lock_out(error_status_lock_out),
  .dc_flush_out(dc_flush_out), .ic_flush_out(ic_flush_out), .control_out(control_out)
);
`default_nettype wire

// file: bench/lsc_mover.sv
// Pipeline model issuing privileged register moves
`timescale 1ns/1ps
`default_nettype none
module lsc_mover (
  // Clock
  input  wire logic        clk_in,
  // Move port
  output logic             mv_valid_out,
  output logic             mv_write_out,
  output logic [3:0]       mv_sel_out,
  output logic [63:0]      mv_wdata_out,
  output logic [29:0]      mv_tag_out,
  input  wire logic        mv_rvalid_in,
  input  wire logic [63:0] mv_rdata_in
);
  initial begin
    {mv_valid_out, mv_write_out, mv_sel_out, mv_wdata_out, mv_tag_out} = '0;
  end
  // One request per call, held across exactly one rising edge
  task automatic move(input logic w, input logic [3:0] s, input logic [63:0] d,
                      output logic [63:0] q, output bit ok);
    int i;
    @(negedge clk_in);
    {mv_valid_out, mv_write_out, mv_sel_out, mv_wdata_out} = {1'b1, w, s, d};
    mv_tag_out = d[42:13];
    @(negedge clk_in);
    mv_valid_out = 1'b0;
    // Released lines stop showing the last request
    mv_sel_out = ~s;
    mv_wdata_out = ~d;
    ok = w;
    q = '0;
    for (i = 0; i < 3 && !ok; i++) begin
      if (mv_rvalid_in === 1'b1) begin
        ok = 1'b1;
        q = mv_rdata_in;
      end else begin
        @(negedge clk_in);
      end
    end
  endtask
endmodule
`default_nettype wire

// file: bench/lsc_top_tb_top.sv
// Self-checking bench for the load/store unit control block
`timescale 1ns/1ps
`default_nettype none
module lsc_top_tb_top;
  logic        clk_in = 1'b0;
  logic        resetn_in;
  logic        mv_v, mv_w, rv, fv, fst, fld, facv, fwr, lk, dsv, kern, sp_o;
  logic        ei, cav, ue, iv, ib, irq, mchk, elock, dcf, icf, icg;
  logic [3:0]  sel;
  logic [63:0] wd, rdat, fva;
  logic [29:0] tag;
  logic [5:0]  fopc;
  logic [4:0]  fdst;
  logic [42:0] dva;
  logic [33:0] dpa, pa_o;
  logic [12:5] eia, ii;
  logic [2:0]  cac;
  logic [15:0] ctl;
  int          mismatches = 0;
  int          n_tests = 0;

  always #4 clk_in = ~clk_in;

  lsc_top dut (
    .clk_in(clk_in), .resetn_in(resetn_in), .mv_valid_in(mv_v), .mv_write_in(mv_w),
    .mv_sel_in(sel), .mv_wdata_in(wd), .mv_tag_in(tag), .mv_rvalid_out(rv),
    .mv_rdata_out(rdat), .fault_valid_in(fv), .fault_va_in(fva), .fault_opcode_in(fopc),
    .fault_dest_in(fdst), .fault_store_in(fst), .fault_load_in(fld), .fault_acv_in(facv),
    .fault_write_in(fwr), .fault_locked_out(lk), .ds_valid_in(dsv), .ds_va_in(dva),
    .ds_pa_in(dpa), .kernel_mode_in(kern), .ds_pa_out(pa_o), .ds_superpage_out(sp_o),
    .external_invalidate_request_in(ei), .invalidate_address_bus_in(eia),
    .cycle_ack_valid_in(cav), .cycle_acknowledge_code_in(cac),
    .uncorrectable_error_in(ue), .dc_inval_valid_out(iv), .dc_inval_index_out(ii),
    .dc_inval_both_out(ib), .corrected_read_irq_out(irq), .machine_check_out(mchk),
    .error_status_lock_out(elock), .dc_flush_out(dcf), .ic_flush_out(icf),
    .ic_flush_nonglobal_out(icg), .control_out(ctl));

  lsc_mover u_mv (
    .clk_in(clk_in), .mv_valid_out(mv_v), .mv_write_out(mv_w), .mv_sel_out(sel),
    .mv_wdata_out(wd), .mv_tag_out(tag), .mv_rvalid_in(rv), .mv_rdata_in(rdat));

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic mv(input logic w, input logic [3:0] s, input logic [63:0] d,
                    output logic [63:0] q);
    bit ok;
    u_mv.move(w, s, d, q, ok);
    if (!ok) begin
      mismatches++;
      $display("[FAIL] %0t read answer missing", $time);
      give_verdict();
    end
  endtask

  task automatic rd(input logic [3:0] s, input logic [63:0] exp);
    logic [63:0] q;
    mv(1'b0, s, 64'h0, q);
    chk(q, exp);
  endtask

  task automatic wt(input logic [3:0] s, input logic [63:0] d);
    logic [63:0] q;
    mv(1'b1, s, d, q);
  endtask

  // Flags in f: store fault, load fault, violation, write
  task automatic flt(input logic [63:0] a, input logic [5:0] o, input logic [4:0] r,
                     input logic [3:0] f);
    @(negedge clk_in);
    {fv, fva, fopc, fdst, fst, fld, facv, fwr} = {1'b1, a, o, r, f};
    @(negedge clk_in);
    fv = 1'b0;
    fva = ~a;
  endtask

  task automatic dsc(input logic [42:0] a, input logic k, input logic [33:0] p,
                     input logic [34:0] e);
    @(negedge clk_in);
    {dsv, dva, kern, dpa} = {1'b1, a, k, p};
    @(negedge clk_in);
    dsv = 1'b0;
    chk(64'({sp_o, pa_o}), 64'(e));
  endtask

  // Kinds in k: external invalidate, uncorrectable error, bus end code
  task automatic ev(input logic [2:0] k, input logic [7:0] ix);
    @(negedge clk_in);
    {ei, ue, cav} = k;
    eia = ix;
    @(negedge clk_in);
    {ei, ue, cav} = 3'b000;
  endtask

  function automatic logic [63:0] ent(input int i);
    return {29'h0, 1'(i), 21'(i * 7 + 3), 10'(i), 3'h0};
  endfunction

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  initial begin
    {fv, fst, fld, facv, fwr, dsv, kern, ei, cav, ue, fva, fopc, fdst} = '0;
    {dva, dpa, eia} = '0;
    cac = 3'h5;
    resetn_in = 1'b0;
    repeat (6) @(negedge clk_in);
    resetn_in = 1'b1;
    chk(64'(ctl), 64'h0);
    chk(64'(lk), 64'h0);
    wt(4'h9, 64'hff7f);
    chk(64'(ctl), 64'hfd7f);
    rd(4'h9, 64'h0);
    rd(4'hb, 64'h0);
    ev(3'b100, 8'ha5);
    chk(64'({iv, ib, ii}), 64'h3a5);
    ev(3'b011, 8'h00);
    chk(64'({mchk, elock, irq}), 64'h4);
    dsc(43'h4abcdef1234, 1'b1, 34'h0, {1'b1, 34'h3cdef1230});
    dsc({13'h1ffe, 30'h0abcde10}, 1'b1, 34'h0, {1'b1, 4'h0, 30'h0abcde14});
    dsc(43'h4abcdef1234, 1'b0, 34'h123456788, {1'b0, 34'h12345678c});
    wt(4'h9, 64'h0);
    chk(64'({dcf, ctl}), 64'h10000);
    ev(3'b110, 8'h3c);
    chk(64'({iv, ib, ii, mchk, elock}), 64'h8f1);
    dsc(43'h4abcdef1234, 1'b1, 34'h123456788, {1'b0, 34'h123456788});
    wt(4'h7, 64'h1);
    chk(64'(icf), 64'h1);
    wt(4'h8, 64'h0);
    chk(64'(icg), 64'h1);
    // Fault capture, lock, and release
    flt(64'hffff800000001238, 6'h2a, 5'h13, 4'b1011);
    chk(64'(lk), 64'h1);
    rd(4'h2, {49'h0, 6'h2a, 5'h13, 4'b1011});
    flt(64'h2222, 6'h15, 5'h0c, 4'b1100);
    rd(4'h2, {49'h0, 6'h2a, 5'h13, 4'b1011});
    rd(4'h3, 64'hffff800000001238);
    chk(64'(lk), 64'h0);
    flt(64'h2222, 6'h15, 5'h0c, 4'b1100);
    rd(4'h2, {49'h0, 6'h15, 5'h0c, 4'b0100});
    wt(4'ha, 64'h0);
    chk(64'(lk), 64'h0);
    // Entry walk through all entries and back to the start
    for (int i = 0; i < 36; i++) wt(4'h0, ent(i));
    for (int i = 0; i < 36; i++) begin
      rd(4'h0, 64'h0);
      rd(4'h1, ent(i));
    end
    rd(4'h0, 64'h0);
    wt(4'h5, 64'h0);
    wt(4'h6, ent(3));
    wt(4'h4, 64'h0);
    rd(4'h0, 64'h0);
    rd(4'h1, ent(0));
    give_verdict();
  end

  initial begin
    #100us;
    mismatches++;
    give_verdict();
  end
endmodule
`default_nettype wire
